// ===== bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vcd_pkg::*;
  logic         clk_sys_in, rst_b_in, lock_cmd, ref_cmd, lk, vx, hold, rv, mid, cs, cr, pd;
  logic [7:0]   rd;
  logic [3:0]   ratio;
  vcd_reg_req_t req;
  int           errors, samples_checked, cal_cnt;
  vcd_vco_control u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_req_in(req),
    .pll_locked_in(lk), .vcxo_ref_ok_in(vx), .reg_rdata_out(rd), .dist_sync_hold_out(hold),
    .ref_valid_out(rv), .vco_force_mid_out(mid), .cal_start_out(cs), .cal_reset_out(cr),
    .div_pwrdn_out(pd), .div_ratio_out(ratio));
  vcd_pll_model u_pll (.clk_in(clk_sys_in), .lock_cmd_in(lock_cmd), .ref_cmd_in(ref_cmd),
    .locked_out(lk), .ref_ok_out(vx));
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // count the start pulse mid-cycle, away from the edge that launches it
  always @(negedge clk_sys_in) if (cs === 1'b1) cal_cnt++;
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys_in);
    req.wr_en = 1'b0;
    @(negedge clk_sys_in);
  endtask
  task rd_chk(input string n, input logic [9:0] a, input logic [7:0] e);
    req.addr = a;
    @(negedge clk_sys_in);
    chk(n, e, rd);
  endtask
  task do_reset;
    rst_b_in = 1'b0;
    repeat (20) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
  endtask
  task conclude;
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog: the sequence needs well under 400 cycles
  initial begin
    #20000;
    errors++;
    conclude();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    req = '0;
    lock_cmd = 1'b0;
    ref_cmd = 1'b0;
    cal_cnt = 0;
    errors = 0;
    samples_checked = 0;
    do_reset();
    chk("hold", 8'h01, {7'h0, hold});
    chk("ratio", 8'h04, {4'h0, ratio});
    wr(10'h3FF, 8'hFF);
    rd_chk("ctl", VCD_ADDR_VCO_CONTROL, 8'h00);
    rd_chk("div", VCD_ADDR_VCO_DIV_CONTROL, 8'h00);
    for (int v = 0; v < 8; v++) begin
      wr(VCD_ADDR_VCO_DIV_CONTROL, {4'hF, v[0], v[2:0]});
      chk("ratio", 8'(v + 4), {4'h0, ratio});
      chk("pwrdn", {7'h0, v[0]}, {7'h0, pd});
      rd_chk("div", VCD_ADDR_VCO_DIV_CONTROL, {4'h0, v[0], v[2:0]});
    end
    ref_cmd = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    chk("refv", 8'h01, {7'h0, rv});
    ref_cmd = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    chk("refv", 8'h00, {7'h0, rv});
    wr(VCD_ADDR_VCO_CONTROL, 8'h0C);
    chk("refv", 8'h01, {7'h0, rv});
    chk("mid", 8'h01, {7'h0, mid});
    chk("hold", 8'h01, {7'h0, hold});
    wr(VCD_ADDR_VCO_CONTROL, 8'h02);
    @(negedge clk_sys_in);
    chk("calcnt", 8'h01, 8'(cal_cnt));
    chk("calrst", 8'h00, {7'h0, cr});
    chk("mid", 8'h00, {7'h0, mid});
    wr(VCD_ADDR_VCO_CONTROL, 8'h02);
    repeat (3) @(negedge clk_sys_in);
    chk("calcnt", 8'h01, 8'(cal_cnt));
    rd_chk("ctl", VCD_ADDR_VCO_CONTROL, 8'h02);
    wr(VCD_ADDR_VCO_CONTROL, 8'h00);
    chk("calrst", 8'h01, {7'h0, cr});
    wr(VCD_ADDR_VCO_CONTROL, 8'h02);
    @(negedge clk_sys_in);
    chk("calcnt", 8'h02, 8'(cal_cnt));
    lock_cmd = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    chk("hold", 8'h00, {7'h0, hold});
    lock_cmd = 1'b0;
    repeat (10) @(negedge clk_sys_in);
    chk("hold", 8'h00, {7'h0, hold});
    do_reset();
    chk("hold", 8'h01, {7'h0, hold});
    wr(VCD_ADDR_VCO_CONTROL, 8'hF0);
    chk("hold", 8'h00, {7'h0, hold});
    rd_chk("ctl", VCD_ADDR_VCO_CONTROL, 8'h10);
    conclude();
  end
endmodule
`default_nettype wire

// ===== bench/vcd_pll_model.sv
`timescale 1ns/1ns
`default_nettype none
module vcd_pll_model #(
  parameter int LOCK_DLY = 4
) (
  input  wire logic clk_in,
  input  wire logic lock_cmd_in,
  input  wire logic ref_cmd_in,
  output logic      locked_out,
  output var logic  ref_ok_out
);
  logic [7:0] cnt;
  // lock needs a settling span, and drops at once when the loop is disturbed
  always_ff @(posedge clk_in) begin
    cnt <= lock_cmd_in ? ((cnt < LOCK_DLY) ? cnt + 8'h01 : cnt) : 8'h00;
    ref_ok_out <= ref_cmd_in;
  end
  assign locked_out = (cnt >= LOCK_DLY);
endmodule
`default_nettype wire

// ===== hw/vcd_pkg.sv
package vcd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [9:0] VCD_ADDR_VCO_CONTROL     = 10'h0F3;
  localparam logic [9:0] VCD_ADDR_VCO_DIV_CONTROL = 10'h0F4;

  // vco_control fields
  localparam int VCD_BIT_FORCE_RELEASE = 4;
  localparam int VCD_BIT_REF_VALID_OVR = 3;
  localparam int VCD_BIT_FORCE_MID     = 2;
  localparam int VCD_BIT_CALIBRATE     = 1;
  localparam logic [7:0] VCD_VCO_CONTROL_MASK = 8'h1E;
  localparam logic [7:0] VCD_VCO_CONTROL_RST  = 8'h00;

  // vco_divider_control fields
  localparam int VCD_BIT_DIV_PWRDN = 3;
  localparam int VCD_DIV_SEL_LSB   = 0;
  localparam int VCD_DIV_SEL_W     = 3;
  localparam logic [7:0] VCD_VCO_DIV_MASK = 8'h0F;
  localparam logic [7:0] VCD_VCO_DIV_RST  = 8'h00;

  // divide ratio is field value plus this base
  localparam logic [3:0] VCD_DIV_BASE = 4'h4;

  typedef enum logic [1:0] {
    VCD_HOLD    = 2'b01,
    VCD_RELEASE = 2'b10
  } vcd_sync_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [9:0] addr;
    logic [7:0] wdata;
  } vcd_reg_req_t;

  typedef struct packed {
    logic [7:0] vco_control;
    logic [7:0] vco_div_control;
    vcd_sync_t  sync_state;
    logic [1:0] lock_sync;
    logic [1:0] vcxo_sync;
    logic       cal_prev;
    logic       cal_start;
    logic [3:0] div_ratio;
    logic [7:0] rdata;
  } vcd_state_t;

endpackage

// ===== hw/vcd_vco_control.sv
// Summary of operation
// - force-release 0: hold distribution in sync until output PLL first locks
// - first lock releases sync automatically with all dividers aligned
// - force-release 1: ignore lock, release distribution sync at once
// - override 0: reference validity follows input cleanup PLL VCXO status
// - override 1: output PLL reference always treated as valid
// - midpoint bit 1 forces VCO control voltage to midscale, else normal
// - writing calibrate 1 while the bit is 0 starts calibration; bit never self-clears
// - writing calibrate 0 resets the VCO calibration logic
// - divider power-down bit 1 powers down VCO divider
// - three-bit divider field selects ratio field plus four, shared by all outputs
`timescale 1ns/1ns
`default_nettype none

module vcd_vco_control
  import vcd_pkg::*;
(
  input  wire logic         clk_sys_in,
  input  wire logic         rst_b_in,
  input  wire vcd_reg_req_t reg_req_in,
  input  wire logic         pll_locked_in,
  input  wire logic         vcxo_ref_ok_in,
  output logic [7:0]        reg_rdata_out,
  output logic              dist_sync_hold_out,
  output logic              ref_valid_out,
  output logic              vco_force_mid_out,
  output logic              cal_start_out,
  output logic              cal_reset_out,
  output logic              div_pwrdn_out,
  output logic [3:0]        div_ratio_out
);

  vcd_state_t st;
  vcd_state_t next_st;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // lock and vcxo status are asynchronous to this clock
    next_st.lock_sync = {st.lock_sync[0], pll_locked_in};
    next_st.vcxo_sync = {st.vcxo_sync[0], vcxo_ref_ok_in};
    if (reg_req_in.wr_en) begin
      unique case (reg_req_in.addr)
        VCD_ADDR_VCO_CONTROL: begin
          next_st.vco_control = reg_req_in.wdata & VCD_VCO_CONTROL_MASK;
        end
        VCD_ADDR_VCO_DIV_CONTROL: begin
          next_st.vco_div_control = reg_req_in.wdata & VCD_VCO_DIV_MASK;
        end
        default: begin
        end
      endcase
    end
    // read data is registered, so it answers the address of the previous cycle
    unique case (reg_req_in.addr)
      VCD_ADDR_VCO_CONTROL:     next_st.rdata = st.vco_control;
      VCD_ADDR_VCO_DIV_CONTROL: next_st.rdata = st.vco_div_control;
      default:                  next_st.rdata = 8'h00;
    endcase
    // release is one-way: a later loss of lock does not re-hold
    unique case (st.sync_state)
      VCD_HOLD: begin
        if (st.lock_sync[1] || st.vco_control[VCD_BIT_FORCE_RELEASE]) begin
          next_st.sync_state = VCD_RELEASE;
        end
      end
      VCD_RELEASE: begin
        next_st.sync_state = VCD_RELEASE;
      end
      default: next_st.sync_state = VCD_HOLD;
    endcase
    next_st.cal_prev  = st.vco_control[VCD_BIT_CALIBRATE];
    next_st.cal_start = st.vco_control[VCD_BIT_CALIBRATE] & ~st.cal_prev;
    // registered so the ratio never glitches while the field is rewritten
    next_st.div_ratio = {1'b0, st.vco_div_control[VCD_DIV_SEL_LSB +: VCD_DIV_SEL_W]}
                        + VCD_DIV_BASE;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st                 <= '0;
      st.vco_control     <= VCD_VCO_CONTROL_RST;
      st.vco_div_control <= VCD_VCO_DIV_RST;
      // start held in sync, whatever the lock pin shows
      st.sync_state      <= VCD_HOLD;
      st.div_ratio       <= VCD_DIV_BASE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out      = st.rdata;
  assign dist_sync_hold_out = (st.sync_state == VCD_HOLD);
  assign ref_valid_out      = st.vco_control[VCD_BIT_REF_VALID_OVR] | st.vcxo_sync[1];
  assign vco_force_mid_out  = st.vco_control[VCD_BIT_FORCE_MID];
  assign cal_start_out      = st.cal_start;
  assign cal_reset_out      = ~st.vco_control[VCD_BIT_CALIBRATE];
  assign div_pwrdn_out      = st.vco_div_control[VCD_BIT_DIV_PWRDN];
  assign div_ratio_out      = st.div_ratio;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // three samples in a row are enough to cross the two-flop synchroniser
  sequence lock_seen_s;
    pll_locked_in ##1 pll_locked_in ##1 pll_locked_in;
  endsequence

  // still held, with neither a synchronised lock nor the force bit to let go
  sequence still_held_s;
    dist_sync_hold_out && !st.lock_sync[1] && !st.vco_control[VCD_BIT_FORCE_RELEASE];
  endsequence

  // one cycle high, then low: a calibration start is a single pulse
  sequence cal_pulse_s;
    cal_start_out ##1 !cal_start_out;
  endsequence

  // register writes as seen by the checks
  logic ctl_write;
  logic div_write;
  assign ctl_write = reg_req_in.wr_en && (reg_req_in.addr == VCD_ADDR_VCO_CONTROL);
  assign div_write = reg_req_in.wr_en && (reg_req_in.addr == VCD_ADDR_VCO_DIV_CONTROL);

  hold_until_lock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    still_held_s |=> dist_sync_hold_out)
    else $error("sync released without cause");
  lock_release_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    lock_seen_s |=> !dist_sync_hold_out)
    else $error("lock did not release sync");
  force_release_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    st.vco_control[VCD_BIT_FORCE_RELEASE] |=> !dist_sync_hold_out)
    else $error("force release ignored");
  release_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !dist_sync_hold_out |=> !dist_sync_hold_out)
    else $error("sync re-held after release");

  // ----------------------------------------------------------------
  // checks: reference, VCO and divider
  // ----------------------------------------------------------------
  // the synchroniser needs two clean edges out of reset before it tracks the pin
  ref_follow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    ($past(rst_b_in, 2) && !st.vco_control[VCD_BIT_REF_VALID_OVR])
      |-> ref_valid_out == $past(vcxo_ref_ok_in, 2))
    else $error("ref valid not following vcxo");
  ref_override_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    st.vco_control[VCD_BIT_REF_VALID_OVR] |-> ref_valid_out)
    else $error("ref override ignored");
  cal_edge_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(st.vco_control[VCD_BIT_CALIBRATE]) |=> cal_pulse_s)
    else $error("calibration start pulse wrong");
  cal_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (!reg_req_in.wr_en && st.vco_control[VCD_BIT_CALIBRATE])
      |=> st.vco_control[VCD_BIT_CALIBRATE])
    else $error("calibrate bit self-cleared");
  cal_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (reg_req_in.wr_en && reg_req_in.addr == VCD_ADDR_VCO_CONTROL
      && !reg_req_in.wdata[VCD_BIT_CALIBRATE]) |=> cal_reset_out)
    else $error("calibration reset missing");
  div_ratio_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (reg_req_in.wr_en && reg_req_in.addr == VCD_ADDR_VCO_DIV_CONTROL)
      |=> ##1 div_ratio_out == $past(reg_req_in.wdata[VCD_DIV_SEL_LSB +: VCD_DIV_SEL_W], 2)
                               + VCD_DIV_BASE)
    else $error("divide ratio wrong");
  pwrdn_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (reg_req_in.wr_en && reg_req_in.addr == VCD_ADDR_VCO_DIV_CONTROL)
      |=> div_pwrdn_out == $past(reg_req_in.wdata[VCD_BIT_DIV_PWRDN]))
    else $error("divider power-down wrong");
  mid_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (reg_req_in.wr_en && reg_req_in.addr == VCD_ADDR_VCO_CONTROL)
      |=> vco_force_mid_out == $past(reg_req_in.wdata[VCD_BIT_FORCE_MID]))
    else $error("midpoint force wrong");

  // ----------------------------------------------------------------
  // checks: start-up, release cause and register side effects
  // ----------------------------------------------------------------
  hold_at_start_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(rst_b_in) |-> dist_sync_hold_out)
    else $error("sync not held after reset");
  reset_defaults_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $rose(rst_b_in) |-> (!vco_force_mid_out && !div_pwrdn_out))
    else $error("control outputs not at default after reset");
  sync_one_hot_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $onehot(st.sync_state))
    else $error("sync state not one-hot");
  release_cause_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(dist_sync_hold_out)
      |-> $past(st.lock_sync[1] || st.vco_control[VCD_BIT_FORCE_RELEASE]))
    else $error("sync released with no lock and no force");

  // a second pulse would restart a calibration that software did not ask for
  cal_single_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cal_start_out |=> !cal_start_out)
    else $error("calibration start longer than one cycle");
  cal_after_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cal_start_out |-> $past(st.vco_control[VCD_BIT_CALIBRATE]))
    else $error("calibration start without calibrate bit");
  cal_run_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (ctl_write && reg_req_in.wdata[VCD_BIT_CALIBRATE])
      |=> !cal_reset_out)
    else $error("calibration held in reset after start");
  cal_rst_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !ctl_write |=> $stable(cal_reset_out))
    else $error("calibration reset moved without a write");

  // outside a write the control outputs must not move on their own
  mid_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !ctl_write |=> $stable(vco_force_mid_out))
    else $error("midpoint force moved without a write");
  pwrdn_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !div_write |=> $stable(div_pwrdn_out))
    else $error("divider power-down moved without a write");
  ratio_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (!div_write ##1 !div_write) |=> $stable(div_ratio_out))
    else $error("divide ratio moved without a write");
  ratio_range_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    div_ratio_out >= VCD_DIV_BASE)
    else $error("divide ratio below base");

endmodule

`default_nettype wire
